// ==== scr_defines.svh ====
// constants of the serial configuration port
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
`define SCR_CLK_PERIOD_NS 8
`define SCR_SCLK_HALF_NS 5000
`define SCR_CS_GAP_NS 10000
`define SCR_REG_FIRST 4'h4
`define SCR_REG_CONFIG 4'h4
`define SCR_REG_CURRENT_REF 4'hb
`define SCR_REG_FINE_ZERO 4'hc
`define SCR_REG_COARSE_ZERO 4'hd
`define SCR_REG_LINEAR 4'he
`define SCR_REG_CHECKSUM 4'hf
`define SCR_DISABLE_BIT 0
`define SCR_INSTR_PASS 8'h7f
`define SCR_CHECKSUM_GOOD 8'hff
`define SCR_EEPROM_READ_OP 8'h03
`define SCR_EEPROM_START_ADDR 8'h04
`define SCR_REG_RESET 8'h00
`endif

// ==== scr_pkg.sv ====
// types of the serial configuration port
package scr_pkg;
   typedef logic [7:0] scr_byte_t;
   typedef enum logic [2:0] {
      SCR_RB_IDLE = 3'b000,
      SCR_RB_CMD = 3'b001,
      SCR_RB_ADDR = 3'b010,
      SCR_RB_DATA = 3'b011,
      SCR_RB_GAP = 3'b100
   } scr_rb_state_e;
endpackage

// ==== scr_rb_if.sv ====
// link between the register core and the read-back engine
`timescale 1ns/100ps
`default_nettype none
interface scr_rb_if;
   logic abort;
   logic stop;
   logic miso;
   logic sclk;
   logic mosi;
   logic cs_n;
   logic busy;
   logic byte_valid;
   logic [3:0] byte_addr;
   scr_pkg::scr_byte_t byte_data;
   modport engine(input abort, stop, miso,
                  output sclk, mosi, cs_n, busy, byte_valid, byte_addr, byte_data);
   modport core(output abort, stop, miso,
                input sclk, mosi, cs_n, busy, byte_valid, byte_addr, byte_data);
endinterface
`default_nettype wire

// ==== scr_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module scr_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta;
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         meta <= RESET_VAL;
         q_out <= RESET_VAL;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== scr_readback.sv ====
// autonomous eeprom read-back engine, master on the serial bus
`include "scr_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module scr_readback (
   input wire logic clock_in,
   input wire logic reset_in,
   scr_rb_if.engine rb_port
);
   localparam int HALF = `SCR_SCLK_HALF_NS / `SCR_CLK_PERIOD_NS;
   localparam int GAP = `SCR_CS_GAP_NS / `SCR_CLK_PERIOD_NS;
   localparam logic [10:0] HALF_LAST = 11'(HALF - 1);
   localparam logic [10:0] GAP_LAST = 11'(GAP - 1);
   scr_pkg::scr_rb_state_e state;
   logic [10:0] cnt;
   logic sclk_q;
   logic [2:0] bit_cnt;
   logic [3:0] byte_cnt;
   scr_pkg::scr_byte_t tx;
   scr_pkg::scr_byte_t rx;
   logic valid_q;
   logic [3:0] addr_q;
   scr_pkg::scr_byte_t data_q;

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         state <= scr_pkg::SCR_RB_IDLE;
         cnt <= 11'h0;
         sclk_q <= 1'b0;
         bit_cnt <= 3'h0;
         byte_cnt <= 4'h0;
         tx <= 8'h00;
         rx <= 8'h00;
         valid_q <= 1'b0;
         addr_q <= 4'h0;
         data_q <= 8'h00;
      end else begin
         valid_q <= 1'b0;
         if (rb_port.abort) begin
            state <= scr_pkg::SCR_RB_IDLE;
            sclk_q <= 1'b0;
            cnt <= 11'h0;
         end else begin
            unique case (state)
               scr_pkg::SCR_RB_IDLE: begin
                  if (!rb_port.stop) begin
                     state <= scr_pkg::SCR_RB_CMD;
                     tx <= `SCR_EEPROM_READ_OP;
                     cnt <= 11'h0;
                     bit_cnt <= 3'h0;
                  end
               end
               scr_pkg::SCR_RB_CMD, scr_pkg::SCR_RB_ADDR, scr_pkg::SCR_RB_DATA: begin
                  if (cnt != HALF_LAST) begin
                     cnt <= cnt + 11'h1;
                  end else if (!sclk_q) begin
                     cnt <= 11'h0;
                     sclk_q <= 1'b1;
                  end else begin
                     cnt <= 11'h0;
                     sclk_q <= 1'b0;
                     rx <= {rx[6:0], rb_port.miso};
                     tx <= {tx[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        if (state == scr_pkg::SCR_RB_CMD) begin
                           state <= scr_pkg::SCR_RB_ADDR;
                           tx <= `SCR_EEPROM_START_ADDR;
                        end else if (state == scr_pkg::SCR_RB_ADDR) begin
                           state <= scr_pkg::SCR_RB_DATA;
                           byte_cnt <= `SCR_REG_FIRST;
                        end else begin
                           valid_q <= 1'b1;
                           addr_q <= byte_cnt;
                           data_q <= {rx[6:0], rb_port.miso};
                           byte_cnt <= byte_cnt + 4'h1;
                           if (byte_cnt == `SCR_REG_CHECKSUM) begin
                              state <= scr_pkg::SCR_RB_GAP;
                           end
                        end
                     end
                  end
               end
               scr_pkg::SCR_RB_GAP: begin
                  if (cnt == GAP_LAST) begin
                     cnt <= 11'h0;
                     state <= scr_pkg::SCR_RB_IDLE;
                  end else begin
                     cnt <= cnt + 11'h1;
                  end
               end
               default: state <= scr_pkg::SCR_RB_IDLE;
            endcase
         end
      end
   end

   assign rb_port.busy = (state != scr_pkg::SCR_RB_IDLE);
   assign rb_port.cs_n = (state == scr_pkg::SCR_RB_IDLE) || (state == scr_pkg::SCR_RB_GAP);
   assign rb_port.sclk = sclk_q;
   assign rb_port.mosi = tx[7];
   assign rb_port.byte_valid = valid_q;
   assign rb_port.byte_addr = addr_q;
   assign rb_port.byte_data = data_q;

   sequence s_frame_end;
      state == scr_pkg::SCR_RB_DATA ##1 state == scr_pkg::SCR_RB_GAP;
   endsequence
   property p_half_width;
      @(posedge clock_in) disable iff (reset_in)
      $rose(sclk_q) |-> $past(cnt) == HALF_LAST;
   endproperty
   a_half_width: assert property (p_half_width) else $error("sclk half period wrong");
   property p_gap_start;
      @(posedge clock_in) disable iff (reset_in)
      s_frame_end |-> rb_port.cs_n && cnt == 11'h0 && !sclk_q;
   endproperty
   a_gap_start: assert property (p_gap_start) else $error("select gap not entered");
   property p_abort_idle;
      @(posedge clock_in) disable iff (reset_in)
      rb_port.abort |=> !rb_port.busy && rb_port.cs_n;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("read-back not aborted");
endmodule
`default_nettype wire

// ==== scr_config_port.sv ====
// serial configuration port with eeprom read-back and checksum
// Functional notes
// - bytes are eight bits, most significant bit first, both directions.
// - first byte is instruction: bit 7 read, low nibble register, bits 6:4 zero.
// - following bytes are data; register pointer increments after each byte.
// - line stays input during writes; driven from second byte of a read.
// - host select low opens a transaction, release ends it.
// - eeprom select stays high during ordinary register reads and writes.
// - instruction 0x7f selects the eeprom until host select is released.
// - read-back engine masters the eeprom and feeds bytes into registers.
// - read-back runs from power-on and restarts after every completed read unless the disable bit stops it.
// - disable bit 0 of register 4 stops read-back after one read while the checksum error flag is clear.
// - host select low aborts read-back; host waits 40 us before clocking.
// - host parks clock low, then selects; device releases line and select.
// - host may use the eeprom while selected; release restarts read-back unless the disable bit stops it.
// - with disable clear, release of host select starts a fresh read.
// - data sampled on rising clock, changed on falling clock.
// - read-back fetches eeprom locations 4 to 15 into same registers.
// - device never writes the eeprom.
// - checksum register write sets or clears the error flag by validity.
// - checksum error forces the lowest under-scale output level.
// - fine and coarse zero trims are signed two's complement codes.
// - linearization trim is an unsigned code from zero to 255.
// - read-back clock half period about 5 us, select gap about 10 us.
// - checksum is end-around-carry sum of registers 4 to 15, equal 0xff.
// - error flag clears at reset; other writes leave it unchanged.
`include "scr_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module scr_config_port (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic serial_clock_in,
   output logic serial_clock_out,
   output logic serial_clock_oe_n_out,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe_n_out,
   input wire logic host_select_n_in,
   output logic eeprom_select_n_out,
   output logic [7:0] coarse_current_ref_trim_out,
   output logic signed [7:0] fine_zero_trim_out,
   output logic signed [7:0] coarse_zero_trim_out,
   output logic [7:0] linearization_trim_out,
   output logic [7:0] config_checksum_out,
   output logic readback_disable_out,
   output logic checksum_error_flag_out,
   output logic under_scale_out
);
   // link clock domain: host framing resets the shifter
   logic frame_rst;
   logic [2:0] link_bit;
   logic [6:0] link_shift;
   logic link_first;
   logic pass_mode;
   logic read_mode;
   scr_pkg::scr_byte_t next_byte;
   scr_pkg::scr_byte_t link_byte;
   logic link_instr;
   logic link_tog;
   logic line_drive_n;
   scr_pkg::scr_byte_t out_shift;
   // core clock domain
   logic host_sel_sync;
   logic host_active;
   logic tog_sync;
   logic tog_seen;
   logic host_evt;
   logic miso_sync;
   logic [3:0] ptr;
   logic wr_ok;
   logic host_wr;
   scr_pkg::scr_byte_t regs [4:15];
   scr_pkg::scr_byte_t rd_hold;
   logic ck_pending;
   logic checksum_error_flag;
   logic [8:0] acc;
   logic sum_ok;
   // engine link, declared ahead of the register bank that reads it
   scr_rb_if rb_bus();

   assign frame_rst = host_select_n_in | reset_in;
   assign next_byte = {link_shift, serial_data_line_in};

   always_ff @(posedge serial_clock_in or posedge frame_rst) begin
      if (frame_rst) begin
         link_bit <= 3'h0;
         link_shift <= 7'h00;
         link_first <= 1'b1;
         pass_mode <= 1'b0;
         read_mode <= 1'b0;
      end else if (!pass_mode) begin
         link_shift <= next_byte[6:0];
         link_bit <= link_bit + 3'h1;
         if (link_bit == 3'h7) begin
            link_first <= 1'b0;
            if (link_first) begin
               pass_mode <= (next_byte == `SCR_INSTR_PASS);
               read_mode <= next_byte[7] && (next_byte[6:4] == 3'h0);
            end
         end
      end
   end

   // byte hand-off word, held until the next completed byte
   always_ff @(posedge serial_clock_in or posedge reset_in) begin
      if (reset_in) begin
         link_byte <= 8'h00;
         link_instr <= 1'b0;
         link_tog <= 1'b0;
      end else if (!pass_mode && link_bit == 3'h7) begin
         link_byte <= next_byte;
         link_instr <= link_first;
         link_tog <= ~link_tog;
      end
   end

   // read data changes on the falling clock edge
   always_ff @(negedge serial_clock_in or posedge frame_rst) begin
      if (frame_rst) begin
         line_drive_n <= 1'b1;
         out_shift <= 8'h00;
      end else if (read_mode && !link_first && link_bit == 3'h0) begin
         line_drive_n <= 1'b0;
         out_shift <= rd_hold;
      end else begin
         out_shift <= {out_shift[6:0], 1'b0};
      end
   end

   scr_sync #(.RESET_VAL(1'b1)) u_sync_select (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .d_in(host_select_n_in),
      .q_out(host_sel_sync)
   );
   scr_sync #(.RESET_VAL(1'b0)) u_sync_toggle (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .d_in(link_tog),
      .q_out(tog_sync)
   );
   scr_sync #(.RESET_VAL(1'b0)) u_sync_data (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .d_in(serial_data_line_in),
      .q_out(miso_sync)
   );

   assign host_active = !host_sel_sync;
   assign host_evt = tog_sync ^ tog_seen;
   assign host_wr = host_evt && !link_instr && wr_ok && (ptr >= `SCR_REG_FIRST);

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         tog_seen <= 1'b0;
      end else begin
         tog_seen <= tog_sync;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ptr <= 4'h0;
         wr_ok <= 1'b0;
      end else if (host_evt) begin
         if (link_instr) begin
            ptr <= link_byte[3:0];
            wr_ok <= !link_byte[7] && (link_byte[6:4] == 3'h0);
         end else begin
            ptr <= ptr + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 4; i <= 15; i++) begin
            regs[i] <= `SCR_REG_RESET;
         end
      end else if (host_wr) begin
         regs[ptr] <= link_byte;
      end else if (rb_bus.byte_valid) begin
         regs[rb_bus.byte_addr] <= rb_bus.byte_data;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rd_hold <= 8'h00;
      end else if (ptr >= `SCR_REG_FIRST) begin
         rd_hold <= regs[ptr];
      end else begin
         rd_hold <= 8'h00;
      end
   end

   always_comb begin
      acc = 9'h000;
      for (int i = 4; i <= 15; i++) begin
         acc = {1'b0, acc[7:0]} + {1'b0, regs[i]};
         acc = {1'b0, acc[7:0]} + {8'h00, acc[8]};
      end
      sum_ok = (acc[7:0] == `SCR_CHECKSUM_GOOD);
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ck_pending <= 1'b0;
         checksum_error_flag <= 1'b0;
      end else begin
         ck_pending <= (host_wr && ptr == `SCR_REG_CHECKSUM)
            || (rb_bus.byte_valid && rb_bus.byte_addr == `SCR_REG_CHECKSUM);
         if (ck_pending) begin
            checksum_error_flag <= !sum_ok;
         end
      end
   end

   assign rb_bus.abort = host_active;
   assign rb_bus.stop = regs[`SCR_REG_CONFIG][`SCR_DISABLE_BIT] && !checksum_error_flag;
   assign rb_bus.miso = miso_sync;

   scr_readback u_readback (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .rb_port(rb_bus.engine)
   );

   assign serial_clock_out = rb_bus.sclk;
   assign serial_clock_oe_n_out = !rb_bus.busy;
   assign serial_data_line_out = rb_bus.busy ? rb_bus.mosi : out_shift[7];
   assign serial_data_line_oe_n_out = rb_bus.busy ? 1'b0 : line_drive_n;
   assign eeprom_select_n_out = rb_bus.cs_n && !pass_mode;
   assign coarse_current_ref_trim_out = regs[`SCR_REG_CURRENT_REF];
   assign fine_zero_trim_out = regs[`SCR_REG_FINE_ZERO];
   assign coarse_zero_trim_out = regs[`SCR_REG_COARSE_ZERO];
   assign linearization_trim_out = regs[`SCR_REG_LINEAR];
   assign config_checksum_out = regs[`SCR_REG_CHECKSUM];
   assign readback_disable_out = regs[`SCR_REG_CONFIG][`SCR_DISABLE_BIT];
   assign checksum_error_flag_out = checksum_error_flag;
   assign under_scale_out = checksum_error_flag;

   sequence s_host_held;
      host_active [*4];
   endsequence
   property p_cse_update;
      @(posedge clock_in) disable iff (reset_in)
      ck_pending |=> checksum_error_flag_out != $past(sum_ok);
   endproperty
   a_cse_update: assert property (p_cse_update) else $error("flag not updated");
   property p_cse_hold;
      @(posedge clock_in) disable iff (reset_in)
      !ck_pending |=> $stable(checksum_error_flag_out);
   endproperty
   a_cse_hold: assert property (p_cse_hold) else $error("flag changed");
   property p_under_scale;
      @(posedge clock_in) disable iff (reset_in)
      ck_pending && !sum_ok |=> under_scale_out;
   endproperty
   a_under_scale: assert property (p_under_scale) else $error("no under-scale");
   property p_eeprom_idle;
      @(posedge clock_in) disable iff (reset_in)
      s_host_held |-> eeprom_select_n_out || pass_mode;
   endproperty
   a_eeprom_idle: assert property (p_eeprom_idle) else $error("eeprom selected");
   property p_ptr_inc;
      @(posedge clock_in) disable iff (reset_in)
      host_evt && !link_instr |=> ptr == $past(ptr) + 4'h1;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
   property p_store;
      @(posedge clock_in) disable iff (reset_in)
      host_wr |=> regs[$past(ptr)] == $past(link_byte);
   endproperty
   a_store: assert property (p_store) else $error("byte not stored");
   property p_abort;
      @(posedge clock_in) disable iff (reset_in)
      $fell(host_sel_sync) |-> ##[1:2] !rb_bus.busy;
   endproperty
   a_abort: assert property (p_abort) else $error("read-back kept running");
   property p_restart;
      @(posedge clock_in) disable iff (reset_in)
      $rose(host_sel_sync) && !rb_bus.stop |-> ##[1:3] rb_bus.busy;
   endproperty
   a_restart: assert property (p_restart) else $error("read-back not resumed");
   property p_write_input;
      @(negedge serial_clock_in) disable iff (frame_rst)
      !read_mode |-> line_drive_n;
   endproperty
   a_write_input: assert property (p_write_input) else $error("line driven in write");
endmodule
`default_nettype wire

// ==== scr_eeprom_model.sv ====
// behavioural serial eeprom answering the read-back engine
`timescale 1ns/100ps
`default_nettype none
module scr_eeprom_model (
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   output logic [15:0] cmd_out,
   output logic [7:0] count_out
);
   logic [7:0] mem [16];
   int k;
   initial begin
      for (k = 0; k < 16; k++) begin
         mem[k] = 8'h41 + 8'(k);
      end
      so_out = 1'b0;
      so_oe_out = 1'b0;
      cmd_out = 16'h0000;
      count_out = 8'h00;
   end
   always @(negedge cs_n_in) begin
      count_out = 8'h00;
   end
   // released when deselected
   always @(posedge cs_n_in) begin
      so_oe_out = 1'b0;
   end
   // opcode and address taken msb first on rising clock
   always @(posedge sclk_in) begin
      if (!cs_n_in) begin
         if (count_out < 8'd16) begin
            cmd_out = {cmd_out[14:0], si_in};
         end
         count_out = count_out + 8'h01;
      end
   end
   // answers read opcode only, data changed on falling clock
   always @(negedge sclk_in) begin
      if (!cs_n_in && count_out >= 8'd16 && cmd_out[15:8] == 8'h03) begin
         so_oe_out = 1'b1;
         so_out = mem[cmd_out[3:0] + count_out[6:3] - 4'h2][~count_out[2:0]];
      end
   end
endmodule
`default_nettype wire

// ==== serial_config_eeprom_readback_bench.sv ====
// self-checking bench of the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module serial_config_eeprom_readback_bench;
   logic clock_in, reset_in, hclk, hdat, hoe, host_sel_n, float_v;
   logic sclk_out, sclk_oe_n, dio_out, dio_oe_n, ee_sel_n, ee_so, ee_oe;
   logic sclk_w, dio_w, dis, flag, under;
   logic [7:0] cur_trim, lin_trim, sum_reg, ee_cnt, r;
   logic signed [7:0] fz_trim, cz_trim;
   logic [15:0] ee_cmd;
   logic [7:0] exp_reg [16];
   int n_fail, total_checks, seed, cycles, k, n;

   assign sclk_w = !sclk_oe_n ? sclk_out : hclk;
   assign dio_w = ee_oe ? ee_so : !dio_oe_n ? dio_out : hoe ? hdat : float_v;

   scr_config_port scr_config_port_i (
      .clock_in(clock_in), .reset_in(reset_in), .serial_clock_in(sclk_w),
      .serial_clock_out(sclk_out), .serial_clock_oe_n_out(sclk_oe_n),
      .serial_data_line_in(dio_w), .serial_data_line_out(dio_out),
      .serial_data_line_oe_n_out(dio_oe_n), .host_select_n_in(host_sel_n),
      .eeprom_select_n_out(ee_sel_n), .coarse_current_ref_trim_out(cur_trim),
      .fine_zero_trim_out(fz_trim), .coarse_zero_trim_out(cz_trim),
      .linearization_trim_out(lin_trim), .config_checksum_out(sum_reg),
      .readback_disable_out(dis), .checksum_error_flag_out(flag),
      .under_scale_out(under));

   scr_eeprom_model scr_eeprom_model_i (
      .sclk_in(sclk_w), .cs_n_in(ee_sel_n), .si_in(dio_w), .so_out(ee_so),
      .so_oe_out(ee_oe), .cmd_out(ee_cmd), .count_out(ee_cnt));

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clock_in) begin
      float_v <= ~float_v;
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_fail++;
         give_verdict;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   function automatic logic [7:0] good_sum;
      int s;
      int j;
      s = 0;
      for (j = 4; j < 15; j++) begin
         s = s + exp_reg[j];
         if (s > 255) s = s - 255;
      end
      return 8'(255 - s);
   endfunction

   // select low, device lets go, then the long setup wait
   task automatic host_open;
      @(posedge clock_in);
      host_sel_n <= 1'b0;
      repeat (5) @(posedge clock_in);
      #1;
      chk(16'({dio_oe_n, ee_sel_n, sclk_oe_n}), 16'h0007);
      repeat (5010) @(posedge clock_in);
      #3;
   endtask

   task automatic host_byte(input logic [7:0] b, input logic rd, output logic [7:0] q);
      int i;
      chk(16'(ee_sel_n), 16'h0001);
      for (i = 7; i >= 0; i--) begin
         hclk = 1'b0;
         hdat = b[i];
         hoe = !rd;
         #32;
         hclk = 1'b1;
         q[i] = dio_w;
         chk(16'(dio_oe_n), 16'(!rd));
         #32;
      end
      #120;
   endtask

   task automatic host_close;
      hclk = 1'b0;
      hoe = 1'b0;
      @(posedge clock_in);
      host_sel_n <= 1'b1;
      repeat (10) @(posedge clock_in);
      #1;
   endtask

   task automatic host_write(input logic [3:0] a, input int cnt);
      logic [7:0] q;
      int i;
      host_open;
      host_byte({4'h0, a}, 1'b0, q);
      for (i = 0; i < cnt; i++) begin
         host_byte(exp_reg[4'(a + i)], 1'b0, q);
      end
      host_close;
   endtask

   task automatic check_regs;
      chk({8'h00, cur_trim}, {8'h00, exp_reg[11]});
      chk({8'h00, fz_trim}, {8'h00, exp_reg[12]});
      chk({8'h00, cz_trim}, {8'h00, exp_reg[13]});
      chk({8'h00, lin_trim}, {8'h00, exp_reg[14]});
      chk({8'h00, sum_reg}, {8'h00, exp_reg[15]});
      chk(16'(fz_trim < 0), 16'(exp_reg[12][7]));
      chk(16'(dis), 16'(exp_reg[4][0]));
   endtask

   initial begin
      seed = 26342;
      n_fail = 0;
      total_checks = 0;
      cycles = 0;
      reset_in = 1'b1;
      hclk = 1'b0;
      hdat = 1'b0;
      hoe = 1'b0;
      host_sel_n = 1'b1;
      float_v = 1'b0;
      for (k = 0; k < 16; k++) exp_reg[k] = 8'h00;
      repeat (6) @(posedge clock_in);
      reset_in <= 1'b0;
      #1;
      chk(16'({flag, under}), 16'h0000);
      check_regs;
      repeat (3) @(posedge clock_in);
      #1;
      chk(16'({ee_sel_n, sclk_oe_n}), 16'h0000);
      // free-running read-back from power-on
      @(posedge sclk_w);
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
      end while (sclk_w === 1'b1);
      chk(16'(n - 1), 16'd625);
      wait (ee_cnt == 8'd24);
      repeat (700) @(posedge clock_in);
      chk(ee_cmd, 16'h0304);
      exp_reg[4] = 8'h45;
      chk(16'(dis), 16'(exp_reg[4][0]));
      $display("test readback done");
      // full bank write with a good checksum and read-back disabled
      for (k = 4; k < 15; k++) exp_reg[k] = 8'($random(seed));
      exp_reg[4][0] = 1'b1;
      exp_reg[15] = good_sum();
      host_write(4'h4, 12);
      check_regs;
      chk(16'({flag, under}), 16'h0000);
      repeat (2000) @(posedge clock_in);
      chk(16'(ee_sel_n), 16'h0001);
      $display("test bank write done");
      host_open;
      host_byte(8'h8b, 1'b0, r);
      for (k = 11; k < 16; k++) begin
         host_byte(8'h00, 1'b1, r);
         chk({8'h00, r}, {8'h00, exp_reg[k]});
      end
      host_close;
      $display("test read done");
      host_open;
      host_byte(8'h7f, 1'b0, r);
      chk(16'({ee_sel_n, dio_oe_n}), 16'h0001);
      host_close;
      chk(16'(ee_sel_n), 16'h0001);
      $display("test pass-through done");
      exp_reg[15] = good_sum() + 8'h01;
      host_write(4'hf, 1);
      chk(16'({flag, under}), 16'h0003);
      exp_reg[11] = 8'($random(seed));
      host_write(4'hb, 1);
      check_regs;
      chk(16'({flag, under}), 16'h0003);
      chk(16'(ee_sel_n), 16'h0000);
      $display("test checksum error done");
      give_verdict;
   end
endmodule
`default_nettype wire
